// File: core/arf_pkg.sv
// Summary of operation
// - Sample rate is 1 kHz (4 kHz in accel bypass) over divider plus one
// - Same strobe paces queue writes and outputs
// - Divider used only when bypass 00, setting 1..6
// - Full queue: policy bit drops new, else overwrites
// - Tag select places frame-sync in chosen low bit
// - Frame-sync latched, locked until strobe captures it
// - Temperature bandwidth from setting and bypass bits
// - Range field selects 2, 4, 8, 16 g
// - Low-power averaging code selects 4..32 samples
// - Accel bypass gives 4 kHz, 1046.0 Hz
// - Accel setting selects bandwidth at 1 kHz
// - Accel output rate also divided by divider
// - Low-power on-time grows with averaging count
// - All four registers reset to zero
`default_nettype none
package arf_pkg;
  // ==========================================================
  // Register map and fields
  localparam logic [7:0] ADDR_RATE_DIV     = 8'h19;
  localparam logic [7:0] ADDR_FILTER_SYNC  = 8'h1a;
  localparam logic [7:0] ADDR_ACCEL_RANGE  = 8'h1c;
  localparam logic [7:0] ADDR_ACCEL_FILTER = 8'h1d;
  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [7:0] MASK_FILTER_SYNC  = 8'h7f;
  localparam logic [7:0] MASK_ACCEL_RANGE  = 8'hf8;
  localparam logic [7:0] MASK_ACCEL_FILTER = 8'h3f;
  localparam int QUEUE_POLICY_BIT = 6;
  localparam int TAG_SEL_LSB      = 3;
  localparam int TEMP_SET_LSB     = 0;
  localparam int SELFTEST_LSB     = 5;
  localparam int RANGE_LSB        = 3;
  localparam int AVG_LSB          = 4;
  localparam int ACCEL_BYPASS_BIT = 3;
  localparam int ACCEL_SET_LSB    = 0;
  localparam logic [2:0] TAG_OFF  = 3'h0;
  localparam logic [2:0] TAG_TEMP = 3'h1;
  localparam logic [2:0] TAG_X    = 3'h5;
  localparam logic [2:0] TAG_Y    = 3'h6;
  localparam logic [2:0] TAG_Z    = 3'h7;
  localparam logic [2:0] TEMP_SET_MAX = 3'h7;

  // ==========================================================
  // Timing
  localparam int SYS_CLK_HZ   = 125_000_000;
  localparam int BASE_RATE_HZ = 1000;
  localparam int FAST_RATE_HZ = 4000;
  localparam int BASE_TICK_CYCLES = SYS_CLK_HZ / BASE_RATE_HZ;
  localparam int FAST_TICK_CYCLES = SYS_CLK_HZ / FAST_RATE_HZ;
  localparam int TICK_W = 17;

  // ==========================================================
  // Filter and power figures
  localparam logic [12:0] TEMP_BW_WIDE  = 13'h0fa0;
  localparam logic [13:0] ACCEL_BW_FAST = 14'h28dc;
  localparam logic [13:0] ON_TIME_FULL  = 14'h043c;
  localparam logic [4:0]  FS_MIN_G      = 5'h02;
  localparam logic [5:0]  AVG_MIN       = 6'h04;
  localparam logic [5:0]  AVG_NONE      = 6'h01;

  typedef struct packed {
    logic [12:0] temp_bw_hz;
    logic [13:0] accel_bw_dhz;
    logic        accel_fast_rate;
    logic [4:0]  full_scale_g;
    logic [5:0]  avg_samples;
    logic [13:0] on_time_us;
    logic [2:0]  selftest_en;
    logic [3:0]  tag_target;
    logic        div_active;
  } arf_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } arf_reg_req_t;

  function automatic logic [12:0] temp_bw(input logic [2:0] s);
    case (s)
      3'h1:    temp_bw = 13'h00bc;
      3'h2:    temp_bw = 13'h0062;
      3'h3:    temp_bw = 13'h002a;
      3'h4:    temp_bw = 13'h0014;
      3'h5:    temp_bw = 13'h000a;
      3'h6:    temp_bw = 13'h0005;
      default: temp_bw = TEMP_BW_WIDE;
    endcase
  endfunction

  // Bandwidth in tenths of a hertz
  function automatic logic [13:0] accel_bw(input logic [2:0] s);
    case (s)
      3'h2:    accel_bw = 14'h03de;
      3'h3:    accel_bw = 14'h01c0;
      3'h4:    accel_bw = 14'h00d4;
      3'h5:    accel_bw = 14'h0066;
      3'h6:    accel_bw = 14'h0033;
      3'h7:    accel_bw = 14'h1068;
      default: accel_bw = 14'h0885;
    endcase
  endfunction

  function automatic logic [13:0] on_time(input logic [1:0] c);
    case (c)
      2'h1:    on_time = 14'h0b18;
      2'h2:    on_time = 14'h12e8;
      2'h3:    on_time = 14'h2288;
      default: on_time = 14'h0730;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: core/arf_pulse_div.sv
`default_nettype none
// ============================================================
// Pulse divider: one pulse per (limit + 1) steps
module arf_pulse_div #(
  parameter int W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset,
  input  wire logic         i_step,
  input  wire logic [W-1:0] i_limit,
  output logic              o_pulse
);
  logic [W-1:0] count;
  wire          wrap = (count >= i_limit);

  // A lowered limit wraps at once instead of running to overflow
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      count   <= '0;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= i_step && wrap;
      if (i_step) begin
        count <= wrap ? '0 : count + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// File: core/arf_config.sv
`default_nettype none
module arf_config #(
  parameter int BASE_TICK_CYCLES = arf_pkg::BASE_TICK_CYCLES,
  parameter int FAST_TICK_CYCLES = arf_pkg::FAST_TICK_CYCLES
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_reset,
  input  wire arf_pkg::arf_reg_req_t i_reg_req,
  output logic [7:0]              o_reg_rdata,
  output logic                    o_reg_rvalid,
  input  wire logic [1:0]         i_filter_bypass_select,
  input  wire logic               i_lowpower_mode,
  input  wire logic               i_frame_sync_input,
  input  wire logic               i_queue_full,
  output logic                    o_sample_strobe,
  output logic                    o_queue_push,
  output logic                    o_queue_drop_oldest,
  output logic                    o_tag_value,
  output arf_pkg::arf_cfg_t       o_cfg
);
  // ==========================================================
  // Registers
  logic [7:0] rate_divider;
  logic [7:0] filter_sync_config;
  logic [7:0] accel_range_selftest;
  logic [7:0] accel_filter_config;

  wire hit_div  = i_reg_req.addr == arf_pkg::ADDR_RATE_DIV;
  wire hit_sync = i_reg_req.addr == arf_pkg::ADDR_FILTER_SYNC;
  wire hit_rng  = i_reg_req.addr == arf_pkg::ADDR_ACCEL_RANGE;
  wire hit_filt = i_reg_req.addr == arf_pkg::ADDR_ACCEL_FILTER;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rate_divider         <= arf_pkg::REG_RESET;
      filter_sync_config   <= arf_pkg::REG_RESET;
      accel_range_selftest <= arf_pkg::REG_RESET;
      accel_filter_config  <= arf_pkg::REG_RESET;
    end else if (i_reg_req.wr) begin
      if (hit_div)  rate_divider <= i_reg_req.wdata;
      if (hit_sync) filter_sync_config <=
          i_reg_req.wdata & arf_pkg::MASK_FILTER_SYNC;
      if (hit_rng)  accel_range_selftest <=
          i_reg_req.wdata & arf_pkg::MASK_ACCEL_RANGE;
      if (hit_filt) accel_filter_config <=
          i_reg_req.wdata & arf_pkg::MASK_ACCEL_FILTER;
    end
  end

  // Unmapped addresses read as zero
  wire [7:0] next_rdata = hit_div  ? rate_divider :
                          hit_sync ? filter_sync_config :
                          hit_rng  ? accel_range_selftest :
                          hit_filt ? accel_filter_config : 8'h00;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_req.rd;
      o_reg_rdata  <= i_reg_req.rd ? next_rdata : o_reg_rdata;
    end
  end

  // ==========================================================
  // Field decode
  wire       keep_on_full = filter_sync_config[arf_pkg::QUEUE_POLICY_BIT];
  wire [2:0] tag_select   =
      filter_sync_config[arf_pkg::TAG_SEL_LSB +: 3];
  wire [2:0] temp_set     =
      filter_sync_config[arf_pkg::TEMP_SET_LSB +: 3];
  wire [2:0] selftest     = accel_range_selftest[arf_pkg::SELFTEST_LSB +: 3];
  wire [1:0] range_select = accel_range_selftest[arf_pkg::RANGE_LSB +: 2];
  wire [1:0] avg_code     = accel_filter_config[arf_pkg::AVG_LSB +: 2];
  wire       accel_bypass = accel_filter_config[arf_pkg::ACCEL_BYPASS_BIT];
  wire [2:0] accel_set    = accel_filter_config[arf_pkg::ACCEL_SET_LSB +: 3];

  wire div_active = (i_filter_bypass_select == 2'b00) &&
                    (temp_set != 3'h0) &&
                    (temp_set != arf_pkg::TEMP_SET_MAX);
  wire temp_wide  = (i_filter_bypass_select != 2'b00) || !div_active;
  wire lp_active  = i_lowpower_mode && !accel_bypass;

  // ==========================================================
  // Sample timing
  logic base_tick;
  logic fast_tick;
  logic sample_pulse;

  arf_pulse_div #(.W(arf_pkg::TICK_W)) u_base_tick (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_step     (1'b1),
    .i_limit    (arf_pkg::TICK_W'(BASE_TICK_CYCLES - 1)),
    .o_pulse    (base_tick)
  );

  arf_pulse_div #(.W(arf_pkg::TICK_W)) u_fast_tick (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_step     (1'b1),
    .i_limit    (arf_pkg::TICK_W'(FAST_TICK_CYCLES - 1)),
    .o_pulse    (fast_tick)
  );

  wire       rate_tick   = accel_bypass ? fast_tick : base_tick;
  wire [7:0] div_limit   = div_active ? rate_divider : 8'h00;

  arf_pulse_div #(.W(8)) u_sample_div (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_step     (rate_tick),
    .i_limit    (div_limit),
    .o_pulse    (sample_pulse)
  );

  // ==========================================================
  // Frame-sync latch
  logic sync_latched;
  logic sync_locked;
  logic sync_captured;

  wire sync_toggle = (!sync_locked || sample_pulse) &&
                     (i_frame_sync_input != sync_latched);
  wire next_locked = sync_toggle ? 1'b1 :
                     sample_pulse ? 1'b0 : sync_locked;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sync_latched  <= 1'b0;
      sync_locked   <= 1'b0;
      sync_captured <= 1'b0;
    end else begin
      sync_locked   <= next_locked;
      sync_latched  <= sync_toggle ? i_frame_sync_input : sync_latched;
      sync_captured <= sample_pulse ? sync_latched : sync_captured;
    end
  end

  // tag target decode, reserved codes untagged
  wire [3:0] tag_target = {tag_select == arf_pkg::TAG_TEMP,
                           tag_select == arf_pkg::TAG_X,
                           tag_select == arf_pkg::TAG_Y,
                           tag_select == arf_pkg::TAG_Z};

  // ==========================================================
  // Queue write and strobes
  // strobe paces queue, policy on full
  wire next_push = sample_pulse && !(i_queue_full && keep_on_full);
  wire next_drop = sample_pulse && i_queue_full && !keep_on_full;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sample_strobe     <= 1'b0;
      o_queue_push        <= 1'b0;
      o_queue_drop_oldest <= 1'b0;
      o_tag_value         <= 1'b0;
    end else begin
      o_sample_strobe     <= sample_pulse;
      o_queue_push        <= next_push;
      o_queue_drop_oldest <= next_drop;
      o_tag_value         <= sample_pulse ? sync_latched : sync_captured;
    end
  end

  // ==========================================================
  // Configuration outputs
  arf_pkg::arf_cfg_t next_cfg;

  always_comb begin
    next_cfg.temp_bw_hz   = temp_wide ? arf_pkg::TEMP_BW_WIDE
                                      : arf_pkg::temp_bw(temp_set);
    next_cfg.accel_bw_dhz = accel_bypass ? arf_pkg::ACCEL_BW_FAST
                                         : arf_pkg::accel_bw(accel_set);
    next_cfg.accel_fast_rate = accel_bypass;
    next_cfg.full_scale_g = arf_pkg::FS_MIN_G << range_select;
    next_cfg.avg_samples  = lp_active ? arf_pkg::AVG_MIN << avg_code
                                      : arf_pkg::AVG_NONE;
    next_cfg.on_time_us   = lp_active ? arf_pkg::on_time(avg_code)
                                      : arf_pkg::ON_TIME_FULL;
    next_cfg.selftest_en  = selftest;
    next_cfg.tag_target   = tag_target;
    next_cfg.div_active   = div_active;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cfg <= '0;
    end else begin
      o_cfg <= next_cfg;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  a_div_ignored: assert property (
    (rate_tick && !div_active) |=> ##1 o_sample_strobe)
    else $error("divider not ignored");
  a_strobe_single: assert property (
    o_sample_strobe |=> !o_sample_strobe)
    else $error("strobe longer than one cycle");
  a_full_discard: assert property (
    (sample_pulse && i_queue_full && keep_on_full)
      |=> !o_queue_push && !o_queue_drop_oldest)
    else $error("sample kept on full queue");
  a_full_overwrite: assert property (
    (sample_pulse && i_queue_full && !keep_on_full)
      |=> o_queue_push && o_queue_drop_oldest)
    else $error("oldest not replaced");
  a_queue_paced: assert property (
    o_queue_push |-> o_sample_strobe)
    else $error("queue write off strobe");
  a_temp_wide: assert property (
    (i_filter_bypass_select != 2'b00) |=> o_cfg.temp_bw_hz == 13'h0fa0)
    else $error("temperature bandwidth not wide");
  a_range_map: assert property (
    1'b1 |=> o_cfg.full_scale_g == (5'h02 << $past(range_select)))
    else $error("full scale mismatch");
  a_avg_count: assert property (
    lp_active |=> o_cfg.avg_samples == (6'h04 << $past(avg_code)))
    else $error("average count mismatch");
  a_accel_fast: assert property (
    accel_bypass |=> o_cfg.accel_fast_rate &&
                     o_cfg.accel_bw_dhz == 14'h28dc)
    else $error("bypass rate wrong");
  a_sync_hold: assert property (
    (sync_locked && !sample_pulse) |=> $stable(sync_latched))
    else $error("latched sync toggled twice");
  a_tag_x: assert property (
    (tag_select == 3'h5) |=> o_cfg.tag_target == 4'h4)
    else $error("x tag target wrong");

  c_div_used:   cover property (div_active && rate_divider != 8'h00
                                && o_sample_strobe);
  c_overwrite:  cover property (o_queue_drop_oldest);
  c_sync_catch: cover property (sync_locked && sample_pulse);
endmodule
`default_nettype wire

// File: verification/arf_host_model.sv
`default_nettype none
// ============================================================
// Host side: issues single-byte register cycles on the bus
module arf_host_model (
  input  wire logic                   i_core_clk,
  output var  arf_pkg::arf_reg_req_t  o_reg_req,
  input  wire logic [7:0]             i_reg_rdata,
  input  wire logic                   i_reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_reg_req = '0;

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_reg_req = '0;
  endtask

  // Answer stands one cycle only, so it is taken in that cycle
  task automatic read_reg(input  logic [7:0] a,
                          output logic [7:0] d,
                          output logic       ok);
    @(negedge i_core_clk);
    o_reg_req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(negedge i_core_clk);
    o_reg_req = '0;
    ok = i_reg_rvalid;
    d  = i_reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: verification/arf_config_test.sv
`default_nettype none
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("[ERR] %0t got %h expected %h", $time, got, exp); \
    end \
  end

module arf_config_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]        fs;
    logic [7:0]        ar;
    logic [7:0]        af;
    logic [1:0]        byp;
    logic              lp;
    arf_pkg::arf_cfg_t cfg;
  } arf_row_t;

  // ==========================================================
  // Short tick counts keep the slow divider cases affordable
  localparam int BASE = 20;
  localparam int FAST = 5;
  localparam arf_pkg::arf_cfg_t RESET_CFG = '{13'h0fa0, 14'h0885, 1'h0,
    5'h02, 6'h01, 14'h043c, 3'h0, 4'h0, 1'h0};
  localparam logic [7:0] ADDRS [4] = '{8'h19, 8'h1a, 8'h1c, 8'h1d};
  localparam logic [7:0] MASKS [4] = '{8'hff, 8'h7f, 8'hf8, 8'h3f};
  localparam arf_row_t ROWS [9] = '{
    '{8'h41, 8'h00, 8'h01, 2'h0, 1'h1, '{13'h00bc, 14'h0885, 1'h0,
      5'h02, 6'h04, 14'h0730, 3'h0, 4'h0, 1'h1}},
    '{8'h0a, 8'h88, 8'h02, 2'h0, 1'h0, '{13'h0062, 14'h03de, 1'h0,
      5'h04, 6'h01, 14'h043c, 3'h4, 4'h8, 1'h1}},
    '{8'h2b, 8'h50, 8'h13, 2'h0, 1'h1, '{13'h002a, 14'h01c0, 1'h0,
      5'h08, 6'h08, 14'h0b18, 3'h2, 4'h4, 1'h1}},
    '{8'h34, 8'h38, 8'h24, 2'h1, 1'h1, '{13'h0fa0, 14'h00d4, 1'h0,
      5'h10, 6'h10, 14'h12e8, 3'h1, 4'h2, 1'h0}},
    '{8'h3d, 8'he0, 8'h35, 2'h2, 1'h1, '{13'h0fa0, 14'h0066, 1'h0,
      5'h02, 6'h20, 14'h2288, 3'h7, 4'h1, 1'h0}},
    '{8'h16, 8'h00, 8'h0e, 2'h0, 1'h0, '{13'h0005, 14'h28dc, 1'h1,
      5'h02, 6'h01, 14'h043c, 3'h0, 4'h0, 1'h1}},
    '{8'h1f, 8'h00, 8'h07, 2'h0, 1'h0, '{13'h0fa0, 14'h1068, 1'h0,
      5'h02, 6'h01, 14'h043c, 3'h0, 4'h0, 1'h0}},
    '{8'h25, 8'h00, 8'h06, 2'h0, 1'h0, '{13'h000a, 14'h0033, 1'h0,
      5'h02, 6'h01, 14'h043c, 3'h0, 4'h0, 1'h1}},
    // Bypass in low power: no averaging, full on-time
    '{8'h00, 8'h00, 8'h38, 2'h0, 1'h1, '{13'h0fa0, 14'h28dc, 1'h1,
      5'h02, 6'h01, 14'h043c, 3'h0, 4'h0, 1'h0}}
  };

  logic                  core_clk = 1'h0;
  logic                  reset    = 1'h1;
  arf_pkg::arf_reg_req_t reg_req;
  logic [7:0]            rdata;
  logic                  rvalid;
  logic [1:0]            byp_sel  = 2'h0;
  logic                  lp_mode  = 1'h0;
  logic                  frame_sync_input    = 1'h0;
  logic                  qfull    = 1'h0;
  logic                  strobe;
  logic                  push;
  logic                  drop;
  logic                  tag;
  arf_pkg::arf_cfg_t     dut_cfg;
  int                    failures    = 0;
  int                    comparisons = 0;

  always #4 core_clk = ~core_clk;

  arf_host_model host_u (
    .i_core_clk   (core_clk),
    .o_reg_req    (reg_req),
    .i_reg_rdata  (rdata),
    .i_reg_rvalid (rvalid)
  );

  arf_config #(
    .BASE_TICK_CYCLES (BASE),
    .FAST_TICK_CYCLES (FAST)
  ) dut_u (
    .i_core_clk             (core_clk),
    .i_reset                (reset),
    .i_reg_req              (reg_req),
    .o_reg_rdata            (rdata),
    .o_reg_rvalid           (rvalid),
    .i_filter_bypass_select (byp_sel),
    .i_lowpower_mode        (lp_mode),
    .i_frame_sync_input     (frame_sync_input),
    .i_queue_full           (qfull),
    .o_sample_strobe        (strobe),
    .o_queue_push           (push),
    .o_queue_drop_oldest    (drop),
    .o_tag_value            (tag),
    .o_cfg                  (dut_cfg)
  );

  // ==========================================================
  // Shared tasks
  task automatic conclude();
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_strobe(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (strobe !== 1'h1 && n < 6000);
    if (n >= 6000) begin
      failures++;
      conclude();
    end
  endtask

  // Second strobe only: the first may still follow the old setting
  task automatic gap(output int n);
    wait_strobe(n);
    wait_strobe(n);
  endtask

  task automatic apply_reset();
    reset = 1'h1;
    repeat (4) @(negedge core_clk);
    reset = 1'h0;
  endtask

  task automatic check_reset();
    logic [7:0] d;
    logic       ok;
    foreach (ADDRS[i]) begin
      host_u.read_reg(ADDRS[i], d, ok);
      `CHK({ok, d}, 9'h100)
    end
    `CHK(dut_cfg, RESET_CFG)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    logic       ok;
    int         n;
    apply_reset();
    check_reset();
    foreach (ROWS[i]) begin
      byp_sel = ROWS[i].byp;
      lp_mode = ROWS[i].lp;
      host_u.write_reg(8'h1a, ROWS[i].fs);
      host_u.write_reg(8'h1c, ROWS[i].ar);
      host_u.write_reg(8'h1d, ROWS[i].af);
      repeat (2) @(negedge core_clk);
      `CHK(dut_cfg, ROWS[i].cfg)
    end
    byp_sel = 2'h0;
    lp_mode = 1'h0;
    foreach (ADDRS[i]) begin
      host_u.write_reg(ADDRS[i], 8'hff);
      host_u.read_reg(ADDRS[i], d, ok);
      `CHK({ok, d}, {1'h1, MASKS[i]})
    end
    host_u.write_reg(8'h1b, 8'h00);
    host_u.read_reg(8'h1b, d, ok);
    `CHK({ok, d}, 9'h100)
    // An unmapped write must leave every mapped register alone
    foreach (ADDRS[i]) begin
      host_u.read_reg(ADDRS[i], d, ok);
      `CHK({ok, d}, {1'h1, MASKS[i]})
    end
    host_u.write_reg(8'h1a, 8'h01);
    host_u.write_reg(8'h1d, 8'h00);
    gap(n);
    `CHK(n, BASE * 256)
    byp_sel = 2'h1;
    gap(n);
    `CHK(n, BASE)
    byp_sel = 2'h0;
    host_u.write_reg(8'h1a, 8'h07);
    gap(n);
    `CHK(n, BASE)
    host_u.write_reg(8'h19, 8'h03);
    host_u.write_reg(8'h1a, 8'h06);
    host_u.write_reg(8'h1d, 8'h08);
    gap(n);
    `CHK(n, FAST * 4)
    host_u.write_reg(8'h1d, 8'h00);
    for (int i = 0; i < 3; i++) begin
      qfull = (i != 0);
      host_u.write_reg(8'h1a, (i == 1) ? 8'h40 : 8'h00);
      repeat (2) @(negedge core_clk);
      wait_strobe(n);
      `CHK({push, drop}, (i == 0) ? 2'h2 : (i == 1) ? 2'h0 : 2'h3)
    end
    qfull = 1'h0;
    host_u.write_reg(8'h1a, 8'h08);
    wait_strobe(n);
    `CHK(tag, 1'h0)
    repeat (3) @(negedge core_clk);
    frame_sync_input = 1'h1;
    @(negedge core_clk);
    frame_sync_input = 1'h0;
    wait_strobe(n);
    `CHK(tag, 1'h1)
    apply_reset();
    check_reset();
    conclude();
  end
endmodule
`default_nettype wire
